// ===== core/boot_loader_pkg.sv
// Shared constants and types for the EEPROM boot configuration loader.
package boot_loader_pkg;

   // Serial read opcode and the first configuration byte address.
   localparam logic [7:0] RD_OPCODE = 8'h03;
   localparam logic [15:0] START_ADDR = 16'h0010;

   // Nominal serial clock and link clock rates, in kHz.
   localparam int SCLK_NOM_KHZ = 1024;
   localparam int LINK_CLK_KHZ = 166667;

   // Half serial period in link cycles, rounded down.
   localparam int HALF_CYC = LINK_CLK_KHZ / (2 * SCLK_NOM_KHZ);
   localparam logic [7:0] HALF_M1 = 8'(HALF_CYC - 1);

   // Link cycles after the rising edge at which the synchronised data is taken.
   localparam logic [7:0] SAMPLE_AT = 8'h02;

   // Link cycles after reset release before the boot strap is latched.
   localparam logic [1:0] STRAP_WAIT = 2'h3;

   // Configuration command codes.
   localparam logic [7:0] CMD_NOP = 8'h00;
   localparam logic [7:0] CMD_REG = 8'h01;
   localparam logic [7:0] CMD_FIR = 8'h02;
   localparam logic [7:0] CMD_IIR = 8'h03;
   localparam logic [7:0] CMD_ROMSEL = 8'h04;
   localparam logic [7:0] CMD_TBS = 8'h05;
   localparam logic [7:0] CMD_ROMTBS = 8'h06;
   localparam logic [7:0] CMD_START = 8'h07;

   // Data words that follow each command before any count is known.
   localparam logic [10:0] REG_WORDS = 11'h002;
   localparam logic [10:0] FIR_HDR_WORDS = 11'h002;
   localparam logic [10:0] IIR_WORDS = 11'h008;
   localparam logic [10:0] ONE_WORD = 11'h001;

   // Largest accepted coefficient and pattern counts.
   localparam logic [10:0] FIR_MAX = 11'h0ff;
   localparam logic [10:0] TBS_MAX = 11'h400;

   // Kinds of configuration events handed to the filter engine.
   typedef enum logic [2:0] {
      EV_REG, EV_FIR, EV_IIR, EV_ROMSEL, EV_TBS, EV_ROMTBS, EV_START
   } evt_kind_t;

   // One configuration event: kind, FIR stage, index or register, data word.
   typedef struct packed {
      evt_kind_t kind;
      logic stage;
      logic [10:0] index;
      logic [23:0] data;
   } cfg_evt_t;

endpackage

// ===== core/eeprom_boot_config_loader.sv
// Boot-time serial EEPROM reader that decodes configuration commands.
//
// Function
// - Strap high after reset: master EEPROM boot.
// - Chip select driven low during the read.
// - Serial clock generated internally, about 1.024 MHz.
// - Output bit changes on falling clock edge.
// - Input bit sampled at the rising edge.
// - Opcode, 16-bit address, then bytes and words.
// - Read opcode 0x03, then sequential data returned.
// - Serial pins high impedance when not transacting.
// - Unused serial pins stay inactive during boot.
// - Fetching begins at address 0x10.
// - Command byte, then its required data words.
// - Fetch until filter start, then stop.
// - Command 0x01 writes a filter register.
// - Data words are three bytes, MSB first.
// - Command 0x02 loads two FIR coefficient sets.
// - Up to 255 coefficients per FIR stage.
// - Command 0x03 takes exactly eight IIR words.
// - IIR coefficients stored in arrival order.
// - Test pattern set of up to 1024 words.
// - Command 0x04 selects on-chip coefficient sets.
// - Command 0x05 loads counted test-pattern words.
// - Command 0x06 selects on-chip test pattern.
// - Command 0x07 starts the filter engine.
`timescale 1ns/1ps
module eeprom_boot_config_loader
   import boot_loader_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_link_clk,
   input wire logic i_boot_strap,
   input wire logic i_miso,
   output logic o_boot_serial_clock,
   output logic o_boot_serial_clock_oe,
   output logic o_mosi,
   output logic o_mosi_oe,
   output logic o_eeprom_select_n,
   output logic o_eeprom_select_n_oe,
   output logic o_miso_oe,
   output cfg_evt_t o_cfg,
   output logic o_cfg_valid,
   output logic o_filter_start,
   output logic o_boot_done
);

   typedef enum {
      PS_WAIT, PS_IDLE, PS_HDR, PS_CMD, PS_WORD, PS_PUSH, PS_END
   } state_t;

   // Clamps a received count word to the largest accepted count.
   function automatic logic [10:0] sat_cnt(input logic [23:0] w, input logic [10:0] lim);
      sat_cnt = (w > {13'h0000, lim}) ? lim : w[10:0];
   endfunction

   logic boot_s1_r, boot_s2_r, miso_s1_r, miso_s2_r;
   logic ack_s1_r, ack_s2_r;
   logic req_s1_r, req_s2_r, req_s3_r;
   logic sclk_r, mosi_r, busy_r, byte_done_r, miso_oe_r;
   logic [7:0] div_cnt_r, tx_r, rx_r;
   logic [2:0] bit_cnt_r;
   state_t state_r;
   logic [1:0] strap_cnt_r, hdr_idx_r, byte_idx_r;
   logic go_r, sel_n_r, pins_oe_r, req_tgl_r;
   logic [7:0] byte_tx_r, cmd_r, n1_r;
   logic [23:0] word_r, word_nxt;
   logic [10:0] wn_r, left_r, reg_addr_r, left_nxt, fir_idx;
   cfg_evt_t evt_r, evt_nxt;
   logic emit_nxt;
   cfg_evt_t cfg_r;
   logic cfg_valid_r, start_r, done_r, ack_tgl_r;

   // Pin synchronisers; only the second stage is read by any logic.
   always_ff @(posedge i_link_clk or posedge i_rst) begin
      if (i_rst) begin
         boot_s1_r <= 1'b0;
         boot_s2_r <= 1'b0;
         miso_s1_r <= 1'b0;
         miso_s2_r <= 1'b0;
      end else begin
         boot_s1_r <= i_boot_strap;
         boot_s2_r <= boot_s1_r;
         miso_s1_r <= i_miso;
         miso_s2_r <= miso_s1_r;
      end
   end

   // Acknowledge toggle coming back from the reference domain.
   always_ff @(posedge i_link_clk or posedge i_rst) begin
      if (i_rst) begin
         ack_s1_r <= 1'b0;
         ack_s2_r <= 1'b0;
      end else begin
         ack_s1_r <= ack_tgl_r;
         ack_s2_r <= ack_s1_r;
      end
   end

   // MISO is an input during boot and the slave-mode drivers never turn on.
   always_ff @(posedge i_link_clk or posedge i_rst) begin
      if (i_rst) begin
         miso_oe_r <= 1'b0;
      end else begin
         miso_oe_r <= 1'b0;
      end
   end

   // Byte shifter: divides the link clock down to the serial clock.
   // The clock rests low between bytes, which mode 0 permits, so the
   // parser can pause the read while an event crosses domains.
   always_ff @(posedge i_link_clk or posedge i_rst) begin
      if (i_rst) begin
         div_cnt_r <= 8'h00;
         sclk_r <= 1'b0;
         mosi_r <= 1'b0;
         tx_r <= 8'h00;
         rx_r <= 8'h00;
         bit_cnt_r <= 3'h0;
         busy_r <= 1'b0;
         byte_done_r <= 1'b0;
      end else begin
         byte_done_r <= 1'b0;
         if (busy_r) begin
            if (div_cnt_r == HALF_M1) begin
               div_cnt_r <= 8'h00;
               sclk_r <= ~sclk_r;
               if (sclk_r) begin
                  // Falling edge: next bit goes out, MSB first.
                  mosi_r <= tx_r[6];
                  tx_r <= {tx_r[6:0], 1'b0};
                  bit_cnt_r <= bit_cnt_r + 3'h1;
                  if (bit_cnt_r == 3'h7) begin
                     busy_r <= 1'b0;
                     byte_done_r <= 1'b1;
                  end
               end
            end else begin
               div_cnt_r <= div_cnt_r + 8'h01;
            end
            // The synchroniser delays MISO by two cycles, so this is the
            // level that stood at the rising edge.
            if (sclk_r && div_cnt_r == SAMPLE_AT) begin
               rx_r <= {rx_r[6:0], miso_s2_r};
            end
         end else if (go_r) begin
            busy_r <= 1'b1;
            tx_r <= byte_tx_r;
            mosi_r <= byte_tx_r[7];
            bit_cnt_r <= 3'h0;
            div_cnt_r <= 8'h00;
         end
      end
   end

   half_period_a:
      assert property (@(posedge i_link_clk) disable iff (i_rst)
         $changed(sclk_r) |-> $past(div_cnt_r) == HALF_M1)
      else $error("serial clock edge off the divider count");

   mosi_fall_a:
      assert property (@(posedge i_link_clk) disable iff (i_rst)
         $changed(mosi_r) |-> !sclk_r)
      else $error("data out changed while serial clock high");

   byte_end_a:
      assert property (@(posedge i_link_clk) disable iff (i_rst)
         byte_done_r |-> $past(sclk_r) && !sclk_r && !busy_r)
      else $error("byte ended away from a falling edge");

   // Next word and event, decoded from the byte that completes a word.
   always_comb begin
      word_nxt = {word_r[15:0], rx_r};
      fir_idx = wn_r - FIR_HDR_WORDS;
      left_nxt = left_r - 11'h001;
      emit_nxt = 1'b0;
      evt_nxt = '0;
      evt_nxt.data = word_nxt;
      case (cmd_r)
         CMD_REG: begin
            evt_nxt.kind = EV_REG;
            evt_nxt.index = reg_addr_r;
            emit_nxt = (wn_r != 11'h000);
         end
         CMD_FIR: begin
            evt_nxt.kind = EV_FIR;
            evt_nxt.stage = (fir_idx >= {3'h0, n1_r});
            evt_nxt.index = evt_nxt.stage ? fir_idx - {3'h0, n1_r} : fir_idx;
            emit_nxt = (wn_r > ONE_WORD);
            if (wn_r == ONE_WORD) begin
               left_nxt = {3'h0, n1_r} + sat_cnt(word_nxt, FIR_MAX);
            end
         end
         CMD_IIR: begin
            evt_nxt.kind = EV_IIR;
            evt_nxt.index = wn_r;
            emit_nxt = 1'b1;
         end
         CMD_ROMSEL: begin
            evt_nxt.kind = EV_ROMSEL;
            emit_nxt = 1'b1;
         end
         CMD_TBS: begin
            evt_nxt.kind = EV_TBS;
            evt_nxt.index = wn_r - ONE_WORD;
            emit_nxt = (wn_r != 11'h000);
            if (wn_r == 11'h000) begin
               left_nxt = sat_cnt(word_nxt, TBS_MAX);
            end
         end
         default: begin
            emit_nxt = 1'b0;
         end
      endcase
   end

   // Parser: one continuous read from the start address, walking the
   // command stream until filter start.
   always_ff @(posedge i_link_clk or posedge i_rst) begin
      if (i_rst) begin
         state_r <= PS_WAIT;
         strap_cnt_r <= 2'h0;
         hdr_idx_r <= 2'h0;
         byte_idx_r <= 2'h0;
         go_r <= 1'b0;
         sel_n_r <= 1'b1;
         pins_oe_r <= 1'b0;
         byte_tx_r <= 8'h00;
         cmd_r <= CMD_NOP;
         n1_r <= 8'h00;
         word_r <= 24'h000000;
         wn_r <= 11'h000;
         left_r <= 11'h000;
         reg_addr_r <= 11'h000;
         evt_r <= '0;
         req_tgl_r <= 1'b0;
      end else begin
         go_r <= 1'b0;
         case (state_r)
            PS_WAIT: begin
               // The strap is caught once the synchroniser has settled.
               strap_cnt_r <= strap_cnt_r + 2'h1;
               if (strap_cnt_r == STRAP_WAIT) begin
                  if (boot_s2_r) begin
                     state_r <= PS_HDR;
                     sel_n_r <= 1'b0;
                     pins_oe_r <= 1'b1;
                     byte_tx_r <= RD_OPCODE;
                     hdr_idx_r <= 2'h0;
                     go_r <= 1'b1;
                  end else begin
                     state_r <= PS_IDLE;
                  end
               end
            end
            PS_HDR: begin
               if (byte_done_r) begin
                  go_r <= 1'b1;
                  hdr_idx_r <= hdr_idx_r + 2'h1;
                  if (hdr_idx_r == 2'h0) begin
                     byte_tx_r <= START_ADDR[15:8];
                  end else if (hdr_idx_r == 2'h1) begin
                     byte_tx_r <= START_ADDR[7:0];
                  end else begin
                     byte_tx_r <= 8'h00;
                     state_r <= PS_CMD;
                  end
               end
            end
            PS_CMD: begin
               if (byte_done_r) begin
                  cmd_r <= rx_r;
                  wn_r <= 11'h000;
                  byte_idx_r <= 2'h0;
                  evt_r <= '0;
                  case (rx_r)
                     CMD_REG: begin
                        left_r <= REG_WORDS;
                        state_r <= PS_WORD;
                        go_r <= 1'b1;
                     end
                     CMD_FIR: begin
                        left_r <= FIR_HDR_WORDS;
                        state_r <= PS_WORD;
                        go_r <= 1'b1;
                     end
                     CMD_IIR: begin
                        left_r <= IIR_WORDS;
                        state_r <= PS_WORD;
                        go_r <= 1'b1;
                     end
                     CMD_ROMSEL, CMD_TBS: begin
                        left_r <= ONE_WORD;
                        state_r <= PS_WORD;
                        go_r <= 1'b1;
                     end
                     CMD_ROMTBS: begin
                        left_r <= 11'h000;
                        evt_r.kind <= EV_ROMTBS;
                        req_tgl_r <= ~req_tgl_r;
                        state_r <= PS_PUSH;
                     end
                     CMD_START: begin
                        left_r <= 11'h000;
                        evt_r.kind <= EV_START;
                        req_tgl_r <= ~req_tgl_r;
                        state_r <= PS_PUSH;
                     end
                     default: begin
                        // No-op and unknown codes carry no data words.
                        left_r <= 11'h000;
                        go_r <= 1'b1;
                     end
                  endcase
               end
            end
            PS_WORD: begin
               if (byte_done_r) begin
                  word_r <= word_nxt;
                  if (byte_idx_r != 2'h2) begin
                     byte_idx_r <= byte_idx_r + 2'h1;
                     go_r <= 1'b1;
                  end else begin
                     byte_idx_r <= 2'h0;
                     wn_r <= wn_r + 11'h001;
                     left_r <= left_nxt;
                     if (cmd_r == CMD_REG && wn_r == 11'h000) begin
                        reg_addr_r <= word_nxt[10:0];
                     end
                     if (cmd_r == CMD_FIR && wn_r == 11'h000) begin
                        n1_r <= 8'(sat_cnt(word_nxt, FIR_MAX));
                     end
                     if (emit_nxt) begin
                        evt_r <= evt_nxt;
                        req_tgl_r <= ~req_tgl_r;
                        state_r <= PS_PUSH;
                     end else begin
                        state_r <= (left_nxt == 11'h000) ? PS_CMD : PS_WORD;
                        go_r <= 1'b1;
                     end
                  end
               end
            end
            PS_PUSH: begin
               // The read pauses until the event has been taken.
               if (ack_s2_r == req_tgl_r) begin
                  if (evt_r.kind == EV_START) begin
                     state_r <= PS_END;
                     sel_n_r <= 1'b1;
                     pins_oe_r <= 1'b0;
                  end else begin
                     state_r <= (left_r == 11'h000) ? PS_CMD : PS_WORD;
                     go_r <= 1'b1;
                  end
               end
            end
            PS_IDLE, PS_END: begin
               sel_n_r <= 1'b1;
               pins_oe_r <= 1'b0;
            end
            default: begin
               state_r <= PS_WAIT;
            end
         endcase
      end
   end

   pins_float_a:
      assert property (@(posedge i_link_clk) disable iff (i_rst)
         !pins_oe_r |-> !sclk_r && sel_n_r && !busy_r)
      else $error("serial bus active while pins released");

   opcode_first_a:
      assert property (@(posedge i_link_clk) disable iff (i_rst)
         $fell(sel_n_r) |-> go_r && byte_tx_r == RD_OPCODE
            ##1 busy_r && mosi_r == RD_OPCODE[7])
      else $error("read did not open with the read opcode");

   start_addr_a:
      assert property (@(posedge i_link_clk) disable iff (i_rst)
         state_r == PS_CMD && $past(state_r == PS_HDR)
            |-> go_r && byte_tx_r == 8'h00 && $past(byte_tx_r) == START_ADDR[7:0])
      else $error("header bytes out of place");

   addr_low_a:
      assert property (@(posedge i_link_clk) disable iff (i_rst)
         state_r == PS_HDR && go_r && hdr_idx_r == 2'h2
            |-> byte_tx_r == START_ADDR[7:0])
      else $error("start address low byte wrong");

   word_msb_a:
      assert property (@(posedge i_link_clk) disable iff (i_rst)
         state_r == PS_WORD && byte_done_r
            |=> word_r == {$past(word_r[15:0]), $past(rx_r)})
      else $error("data word not built most significant byte first");

   iir_order_a:
      assert property (@(posedge i_link_clk) disable iff (i_rst)
         $rose(state_r == PS_PUSH) && evt_r.kind == EV_IIR
            |-> evt_r.index < IIR_WORDS && evt_r.index == wn_r - 11'h001)
      else $error("IIR coefficient index out of order");

   fir_limit_a:
      assert property (@(posedge i_link_clk) disable iff (i_rst)
         state_r == PS_PUSH && evt_r.kind == EV_FIR
            |-> evt_r.index < FIR_MAX)
      else $error("FIR coefficient index beyond stage limit");

   stop_after_a:
      assert property (@(posedge i_link_clk) disable iff (i_rst)
         state_r == PS_END |-> sel_n_r && !go_r && !busy_r)
      else $error("read continued after filter start");

   // Event request crossing into the reference domain.
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         req_s1_r <= 1'b0;
         req_s2_r <= 1'b0;
         req_s3_r <= 1'b0;
      end else begin
         req_s1_r <= req_tgl_r;
         req_s2_r <= req_s1_r;
         req_s3_r <= req_s2_r;
      end
   end

   // Event capture: the bundle is stable until acknowledged, so it is
   // safe to load it once the request toggle has settled.
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         cfg_r <= '0;
         cfg_valid_r <= 1'b0;
         start_r <= 1'b0;
         done_r <= 1'b0;
         ack_tgl_r <= 1'b0;
      end else begin
         cfg_valid_r <= 1'b0;
         start_r <= 1'b0;
         if (req_s2_r != req_s3_r) begin
            cfg_r <= evt_r;
            cfg_valid_r <= 1'b1;
            ack_tgl_r <= req_s2_r;
            if (evt_r.kind == EV_START) begin
               start_r <= 1'b1;
               done_r <= 1'b1;
            end
         end
      end
   end

   start_pulse_a:
      assert property (@(posedge i_ref_clk) disable iff (i_rst)
         start_r |-> cfg_valid_r && cfg_r.kind == EV_START
            ##1 !start_r && done_r)
      else $error("filter start not a single flagged pulse");

   // Outputs straight from their flip-flops.
   assign o_boot_serial_clock = sclk_r;
   assign o_boot_serial_clock_oe = pins_oe_r;
   assign o_mosi = mosi_r;
   assign o_mosi_oe = pins_oe_r;
   assign o_eeprom_select_n = sel_n_r;
   assign o_eeprom_select_n_oe = pins_oe_r;
   assign o_miso_oe = miso_oe_r;
   assign o_cfg = cfg_r;
   assign o_cfg_valid = cfg_valid_r;
   assign o_filter_start = start_r;
   assign o_boot_done = done_r;

endmodule // eeprom_boot_config_loader

// ===== verif/eeprom_model.sv
// Behavioural mode-0 serial EEPROM that answers one continuous read.
`timescale 1ns/1ps
module eeprom_model (
   input wire logic i_sck,
   input wire logic i_cs_n,
   input wire logic i_mosi,
   output logic o_miso
);
   // Only 256 bytes are modelled, so the address wraps at the low byte.
   logic [7:0] mem [0:255];
   logic [23:0] hdr = 24'h0;
   int bits = 0;
   int rises = 0;
   int err = 0;
   int k;
   realtime t_rise = 0.0;
   realtime per = 0.0;
   realtime t_mosi = 0.0;
   initial o_miso = 1'b0;
   // A fresh select restarts the opcode and address header.
   always @(negedge i_cs_n) bits = 0;
   always @(i_mosi) t_mosi = $realtime;
   // Sample at the rise; a data change close before it means a wrong launch edge.
   always @(posedge i_sck) begin
      if (!i_cs_n) begin
         if ($realtime - t_mosi < 100.0) err++;
         per = $realtime - t_rise;
         t_rise = $realtime;
         if (bits < 24) hdr = {hdr[22:0], i_mosi};
         bits++;
         rises++;
      end
   end
   // Bytes from the latched address onward, MSB first, changed on falls.
   always @(negedge i_sck) begin
      if (!i_cs_n && bits >= 24) begin
         k = bits - 24;
         o_miso = mem[8'(hdr[7:0] + k / 8)][7 - k % 8];
      end
   end
   // The data line has no pull, so a released line shows the inverse level.
   always @(posedge i_cs_n) o_miso = ~o_miso;
endmodule // eeprom_model

// ===== verif/eeprom_boot_config_loader_tb_top.sv
// Testbench for the boot configuration loader against a serial EEPROM model.
`timescale 1ns/1ps
module eeprom_boot_config_loader_tb_top import boot_loader_pkg::*;;
   logic i_ref_clk = 1'b0;
   logic i_link_clk = 1'b0;
   logic i_rst = 1'b1;
   logic i_boot_strap = 1'b1;
   logic sck, sck_oe, mosi, mosi_oe, sel_n, sel_oe, miso_oe, miso, cfg_valid, start, done;
   logic mosi_hold = 1'b0;
   cfg_evt_t cfg;
   cfg_evt_t exp_q[$];
   cfg_evt_t got_q[$];
   int fail_count = 0;
   int checked = 0;
   int cyc = 0;
   int a;
   always #4 i_ref_clk = ~i_ref_clk;
   always #3 i_link_clk = ~i_link_clk;
   // Select is pulled up and clock pulled down; data shows the inverse when released.
   always @(mosi) if (mosi_oe) mosi_hold = mosi;
   wire logic sck_w = sck_oe ? sck : 1'b0;
   wire logic cs_w = sel_oe ? sel_n : 1'b1;
   wire logic mosi_w = mosi_oe ? mosi : ~mosi_hold;
   eeprom_boot_config_loader eeprom_boot_config_loader_inst (
      .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_link_clk(i_link_clk),
      .i_boot_strap(i_boot_strap), .i_miso(miso), .o_boot_serial_clock(sck),
      .o_boot_serial_clock_oe(sck_oe), .o_mosi(mosi), .o_mosi_oe(mosi_oe),
      .o_eeprom_select_n(sel_n), .o_eeprom_select_n_oe(sel_oe), .o_miso_oe(miso_oe),
      .o_cfg(cfg), .o_cfg_valid(cfg_valid), .o_filter_start(start), .o_boot_done(done));
   eeprom_model eeprom_model_inst (.i_sck(sck_w), .i_cs_n(cs_w), .i_mosi(mosi_w), .o_miso(miso));
   task automatic chk(input string what, input logic [38:0] seen, input logic [38:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wrap_up();
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // Log events, tie the start pulse to the start event, and guard against a hang.
   always @(posedge i_ref_clk) begin
      cyc++;
      if (cfg_valid === 1'b1) begin
         got_q.push_back(cfg);
         chk("start_pulse", 39'(start), 39'(cfg.kind == EV_START));
      end
      if (miso_oe !== 1'b0) chk("miso_oe", 39'(miso_oe), 39'h0);
      if (cyc == 90000) begin
         fail_count++;
         wrap_up();
      end
   end
   task automatic b(input logic [7:0] v);
      eeprom_model_inst.mem[a] = v;
      a++;
   endtask
   // Words go out most significant byte first.
   task automatic w(input logic [23:0] v);
      b(v[23:16]);
      b(v[15:8]);
      b(v[7:0]);
   endtask
   task automatic e(input evt_kind_t k, input logic s, input logic [10:0] i, input logic [23:0] d);
      exp_q.push_back(cfg_evt_t'{k, s, i, d});
   endtask
   task automatic do_reset(input logic strap);
      i_rst <= 1'b1;
      i_boot_strap <= strap;
      repeat (20) @(posedge i_ref_clk);
      i_rst <= 1'b0;
   endtask
   // Full image with every command; the header area holds start codes to catch a wrong origin.
   task automatic scen_boot();
      int n;
      int nb;
      for (n = 0; n < 256; n++) eeprom_model_inst.mem[n] = CMD_START;
      a = 16;
      b(CMD_ROMSEL);
      w(24'h002200);
      e(EV_ROMSEL, 0, 0, 24'h002200);
      b(CMD_ROMTBS);
      e(EV_ROMTBS, 0, 0, 0);
      b(CMD_REG);
      w(24'h000020);
      w(24'h070431);
      e(EV_REG, 0, 11'h020, 24'h070431);
      b(CMD_NOP);
      b(CMD_FIR);
      w(24'h1);
      w(24'h2);
      w(24'h00022e);
      w(24'hfffe8d);
      w(24'hffffb9);
      e(EV_FIR, 0, 0, 24'h00022e);
      e(EV_FIR, 1, 0, 24'hfffe8d);
      e(EV_FIR, 1, 1, 24'hffffb9);
      b(CMD_IIR);
      for (n = 0; n < 8; n++) begin
         w(24'(24'h111111 * (n + 1)));
         e(EV_IIR, 0, 11'(n), 24'(24'h111111 * (n + 1)));
      end
      b(CMD_TBS);
      w(24'h2);
      w(24'h0007da);
      w(24'h000fb5);
      e(EV_TBS, 0, 0, 24'h0007da);
      e(EV_TBS, 0, 1, 24'h000fb5);
      b(CMD_START);
      e(EV_START, 0, 0, 0);
      nb = a - 16;
      do_reset(1'b1);
      for (n = 0; n < 85000 && done !== 1'b1; n++) @(posedge i_ref_clk);
      repeat (20) @(posedge i_ref_clk);
      chk("event_count", 39'(got_q.size()), 39'(exp_q.size()));
      foreach (exp_q[i]) if (i < got_q.size()) chk("event", got_q[i], exp_q[i]);
      chk("header", 39'(eeprom_model_inst.hdr), {15'h0, RD_OPCODE, START_ADDR});
      chk("mosi_launch", 39'(eeprom_model_inst.err), 39'h0);
      chk("sck_rate", 39'(eeprom_model_inst.per >= 960.0 && eeprom_model_inst.per <= 990.0), 39'h1);
      chk("released", {35'h0, sel_oe, sck_oe, mosi_oe, sel_n}, 39'h1);
      repeat (2000) @(posedge i_ref_clk);
      chk("clock_rises", 39'(eeprom_model_inst.rises), 39'((nb + 3) * 8));
      chk("done_held", 39'(done), 39'h1);
   endtask
   // Strap low: the port must stay released and silent.
   task automatic scen_strap_low();
      int n;
      int r;
      n = got_q.size();
      r = eeprom_model_inst.rises;
      do_reset(1'b0);
      repeat (600) @(posedge i_ref_clk);
      chk("no_events", 39'(got_q.size()), 39'(n));
      chk("no_clock", 39'(eeprom_model_inst.rises), 39'(r));
      chk("pins_off", {35'h0, sel_oe, sck_oe, mosi_oe, done}, 39'h0);
   endtask
   initial begin
      scen_boot();
      scen_strap_low();
      wrap_up();
   end
endmodule // eeprom_boot_config_loader_tb_top
